//--- shared/adccc_pkg.sv
// adccc_pkg: constants and carriers for the converter conversion control
// assumes a 50 MHz system clock; converter clock is derived by a tick divider
//
// Behaviour
// - resolution defaults to ten bits
// - resolution field 00..11 gives 6/8/10/12 bits
// - alignment 0 left, 1 right, zero padded
// - differential: input zero inverting, other non-inverting
// - reference select 1 external, 0 bandgap
// - input select 0..3 routes inputs 0..3
// - select top bit converts supply third, bandgap
// - channel from command or configuration field
// - overflow flag stored after every conversion
// - power-on cleared switches converter off
// - start by start_n rise or command
// - start at first converter tick after select high
// - single mode: one conversion then done pulse
// - start_n low or new command aborts
// - conversion takes N/2 plus three ticks
// - continuous mode repeats, pulsing done each result
// - continuous interval N/2 plus one ticks
// - converter logic paced by 500 kHz clock
// - command byte is 1100 then input select
package adccc_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CONV_CLK_HZ = 500_000;
   localparam int unsigned CONV_DIV = CLK_HZ / CONV_CLK_HZ;
   localparam logic [1:0] RES_RESET = 2'h2;
   localparam logic [3:0] START_CMD_OP = 4'hc;
   localparam logic [3:0] CONV_EXTRA = 4'h3;
   localparam logic [3:0] CYCLE_EXTRA = 4'h1;
   localparam int unsigned SAMPLE_W = 12;
   localparam int unsigned RESULT_W = 16;

   typedef enum logic [1:0] {
      ADCCC_IDLE = 2'b00,
      ADCCC_ARMED = 2'b01,
      ADCCC_CONV = 2'b10,
      ADCCC_WAIT = 2'b11
   } adccc_state_type;

   // configuration fields as written by the controller
   typedef struct packed {
      logic power_on;
      logic start_trigger_n;
      logic continuous_run;
      logic differential;
      logic result_alignment;
      logic reference_select;
      logic [1:0] resolution_select;
      logic [3:0] input_select;
   } adccc_cfg_type;

   // analog front-end steering
   typedef struct packed {
      logic enable;
      logic sample;
      logic [2:0] pos_input;
      logic neg_is_input0;
      logic use_ext_ref;
   } adccc_mux_type;

   function automatic logic [3:0] adccc_bits(input logic [1:0] res);
      adccc_bits = {res, 1'b0} + 4'h6;
   endfunction : adccc_bits

   function automatic logic [3:0] adccc_half(input logic [1:0] res);
      // half of 6/8/10/12 is 3/4/5/6
      adccc_half = {2'b00, res} + 4'h3;
   endfunction : adccc_half
endpackage : adccc_pkg

//--- hdl/adccc_align.sv
// adccc_align: places a raw sample into the 16-bit result word
// combinational; the caller registers the output
`timescale 1ns/1ns
`default_nettype none
module adccc_align
   import adccc_pkg::*;
(
   // sample in
   input wire logic [adccc_pkg::SAMPLE_W-1:0] i_sample,
   input wire logic [1:0] i_res,
   input wire logic i_right,
   // aligned word out
   output logic [adccc_pkg::RESULT_W-1:0] o_word
);
   logic [RESULT_W-1:0] left_word;
   logic [RESULT_W-1:0] right_word;
   logic [3:0] nbits;
   always_comb begin
      nbits = adccc_bits(i_res);
      // sample arrives msb-aligned at bit 11; trim unused low bits
      right_word = RESULT_W'(i_sample >> (4'hc - nbits));
      left_word = RESULT_W'({i_sample, 4'h0});
      left_word = left_word & ~(16'hffff >> nbits);
      o_word = i_right ? right_word : left_word;
   end
endmodule : adccc_align
`default_nettype wire

//--- hdl/adccc_ctrl.sv
// adccc_ctrl: conversion sequencing for the four-input converter
// assumes the register port decodes writes into i_cfg/i_cmd strobes and
// the analog core returns a sample and overflow bit when sampled
`timescale 1ns/1ns
`default_nettype none
module adccc_ctrl
   import adccc_pkg::*;
#(
   parameter int unsigned DIV = adccc_pkg::CONV_DIV
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // register port side
   input wire adccc_pkg::adccc_cfg_type i_cfg,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_byte,
   input wire logic i_port_select_n,
   // analog core
   input wire logic [adccc_pkg::SAMPLE_W-1:0] i_conversion_value,
   input wire logic i_overflow,
   // results
   output logic [adccc_pkg::RESULT_W-1:0] o_conversion_result,
   output logic o_range_overflow_flag,
   output logic o_conversion_done,
   output logic o_busy,
   output adccc_pkg::adccc_mux_type o_mux
);
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [7:0] div;
      logic tick;
      adccc_state_type state;
      logic [3:0] count;
      logic cmd_chan;
      logic [3:0] chan;
      logic start_n_last;
      logic [1:0] res;
      logic [RESULT_W-1:0] result;
      logic ovf;
      logic done;
      logic busy;
      adccc_mux_type mux;
   } adccc_st_type;

   adccc_st_type st_reg;
   adccc_st_type st_next;
   logic rst_q_n;
   logic trig;
   logic [RESULT_W-1:0] aligned;
   logic [3:0] sel;

   assign rst_q_n = st_reg.rst_sync[1];

   adccc_align u_align (
      .i_sample(i_conversion_value),
      .i_res(st_reg.res),
      .i_right(i_cfg.result_alignment),
      .o_word(aligned)
   );

   always_comb begin
      st_next = st_reg;
      st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
      st_next.done = 1'b0;
      st_next.mux.sample = 1'b0;
      // converter tick at 500 kHz
      st_next.tick = 1'b0;
      if (st_reg.div == 8'(DIV - 1)) begin
         st_next.div = 8'h0;
         st_next.tick = 1'b1;
      end else begin
         st_next.div = st_reg.div + 8'h1;
      end
      st_next.start_n_last = i_cfg.start_trigger_n;
      // a command byte with the start opcode is a trigger
      trig = (i_cmd_valid && i_cmd_byte[7:4] == START_CMD_OP) ||
         (i_cfg.start_trigger_n && !st_reg.start_n_last);
      if (i_cmd_valid && i_cmd_byte[7:4] == START_CMD_OP) begin
         st_next.cmd_chan = 1'b1;
         st_next.chan = i_cmd_byte[3:0];
      end else if (trig) begin
         st_next.cmd_chan = 1'b0;
      end
      sel = st_next.cmd_chan ? st_next.chan : i_cfg.input_select;
      st_next.mux.enable = i_cfg.power_on;
      st_next.mux.pos_input = sel[3] ? 3'h4 : {1'b0, sel[1:0]};
      st_next.mux.neg_is_input0 = i_cfg.differential && !sel[3];
      st_next.mux.use_ext_ref = i_cfg.reference_select && !sel[3];
      case (st_reg.state)
         ADCCC_IDLE: begin
            if (trig) begin
               st_next.state = ADCCC_ARMED;
            end
         end
         ADCCC_ARMED: begin
            // wait for the port to close and the next tick
            if (i_port_select_n && st_reg.tick) begin
               st_next.state = ADCCC_CONV;
               st_next.res = i_cfg.resolution_select;
               st_next.count = adccc_half(i_cfg.resolution_select) +
                  CONV_EXTRA;
               st_next.mux.sample = 1'b1;
            end
         end
         ADCCC_CONV: begin
            if (st_reg.tick) begin
               if (st_reg.count == 4'h1) begin
                  st_next.result = aligned;
                  st_next.ovf = i_overflow;
                  st_next.done = 1'b1;
                  if (i_cfg.continuous_run) begin
                     st_next.state = ADCCC_CONV;
                     st_next.count = adccc_half(st_reg.res) +
                        CYCLE_EXTRA;
                     st_next.mux.sample = 1'b1;
                  end else begin
                     st_next.state = ADCCC_IDLE;
                  end
               end else begin
                  st_next.count = st_reg.count - 4'h1;
               end
            end
         end
         default: begin
            st_next.state = ADCCC_IDLE;
         end
      endcase
      // abort: start_n low returns to idle, a fresh command restarts the sequence
      if (!i_cfg.start_trigger_n && st_reg.state != ADCCC_IDLE) begin
         st_next.state = ADCCC_IDLE;
      end
      if (i_cmd_valid && i_cmd_byte[7:4] == START_CMD_OP) begin
         st_next.state = ADCCC_ARMED;
      end
      if (!i_cfg.power_on) begin
         st_next.state = ADCCC_IDLE;
      end
      // busy is registered so the output comes straight from a flop
      st_next.busy = st_next.state != ADCCC_IDLE;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
         st_reg.res <= RES_RESET;
         st_reg.start_n_last <= 1'b1;
      end else if (!rst_q_n) begin
         st_reg <= '0;
         st_reg.rst_sync <= {st_reg.rst_sync[0], 1'b1};
         st_reg.res <= RES_RESET;
         st_reg.start_n_last <= 1'b1;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   assign o_conversion_result = st_reg.result;
   assign o_range_overflow_flag = st_reg.ovf;
   assign o_conversion_done = st_reg.done;
   assign o_busy = st_reg.busy;
   assign o_mux = st_reg.mux;

   // done lasts exactly one system cycle, result is fresh then
   done_pulse_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      o_conversion_done && i_ce |=> !o_conversion_done)
      else $error("done pulse too long");
   done_result_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      $rose(o_conversion_done) |-> o_conversion_result == $past(aligned))
      else $error("result not stored with done");
   off_idle_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      !i_cfg.power_on && i_ce |=> !o_busy)
      else $error("busy while powered off");
   abort_n_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      !i_cfg.start_trigger_n && !i_cmd_valid && i_ce |=> !o_busy)
      else $error("no abort on start low");
   supply_ref_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      sel[3] && i_ce |=> !o_mux.use_ext_ref)
      else $error("supply uses external ref");
   cmd_arm_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      i_cmd_valid && i_cmd_byte[7:4] == 4'hc && i_cfg.power_on && i_ce
      |=> o_busy)
      else $error("command did not arm");
   wait_port_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      st_reg.state == ADCCC_ARMED && !i_port_select_n && i_ce
      |=> st_reg.state != ADCCC_CONV)
      else $error("started with port open");
   diff_neg_a: assert property (@(posedge i_clk) disable iff (!rst_q_n)
      i_cfg.differential && !sel[3] && i_ce |=> o_mux.neg_is_input0)
      else $error("differential not set");
   single_c: cover property (@(posedge i_clk) o_conversion_done && !i_cfg.continuous_run);
   cont_c: cover property (@(posedge i_clk) o_conversion_done && i_cfg.continuous_run);
   abort_c: cover property (@(posedge i_clk) st_reg.state == ADCCC_CONV && !i_cfg.start_trigger_n);
endmodule : adccc_ctrl
`default_nettype wire

//--- testbench/adccc_mcu_model.sv
// adccc_mcu_model: controller side of the internal register port
// assumes the bench supplies the clock and calls the tasks by hierarchy
`timescale 1ns/1ns
`default_nettype none
module adccc_mcu_model
   import adccc_pkg::*;
(
   // clock
   input wire logic i_clk,
   // register port
   output adccc_pkg::adccc_cfg_type o_cfg,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_byte,
   output logic o_port_select_n
);
   import adccc_pkg::*;
   initial begin
      o_cfg = 12'hc20;
      o_cmd_valid = 1'b0;
      o_cmd_byte = 8'h00;
      o_port_select_n = 1'b1;
   end
   task automatic write_cfg(input adccc_cfg_type c);
      @(posedge i_clk);
      o_port_select_n <= 1'b0;
      o_cfg <= c;
      @(posedge i_clk);
      o_port_select_n <= 1'b1;
   endtask : write_cfg
   // byte is scrambled once released so a stale value never looks valid
   task automatic send_cmd(input logic [3:0] sel);
      @(posedge i_clk);
      o_port_select_n <= 1'b0;
      o_cmd_valid <= 1'b1;
      o_cmd_byte <= {START_CMD_OP, sel};
      @(posedge i_clk);
      o_cmd_valid <= 1'b0;
      o_cmd_byte <= ~{START_CMD_OP, sel};
      @(posedge i_clk);
      o_port_select_n <= 1'b1;
   endtask : send_cmd
endmodule : adccc_mcu_model
`default_nettype wire

//--- testbench/adc_conversion_control_bench.sv
// adc_conversion_control_bench: self-checking bench for adccc_ctrl
// assumes DIV shortened to 4; analog core modelled by bench values
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control_bench;
   import adccc_pkg::*;
   localparam int DIV = 4;
   localparam int LIM = 2000;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [11:0] smp = 12'h000;
   logic ovf = 1'b0;
   adccc_cfg_type cfg;
   adccc_cfg_type c;
   adccc_mux_type mux;
   logic cmd_valid, psn, done, flag;
   logic [7:0] cmd_byte;
   logic [15:0] result;
   int fails = 0;
   int checks_done = 0;
   int n;
   logic [3:0] sels [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hd};
   always #10 i_clk = ~i_clk;
   adccc_mcu_model adccc_mcu_model_i (.i_clk(i_clk), .o_cfg(cfg),
      .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte), .o_port_select_n(psn));
   adccc_ctrl #(.DIV(DIV)) adccc_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_ce(1'b1), .i_cfg(cfg), .i_cmd_valid(cmd_valid),
      .i_cmd_byte(cmd_byte), .i_port_select_n(psn),
      .i_conversion_value(smp), .i_overflow(ovf),
      .o_conversion_result(result), .o_range_overflow_flag(flag),
      .o_conversion_done(done), .o_busy(), .o_mux(mux));
   task automatic finish_test();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   task automatic chk(input bit ok, input string m);
      checks_done++;
      if (!ok) begin
         fails++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // reference model: top n bits of the sample, placed left or right
   function automatic logic [15:0] exp_word(int r, bit right);
      int w;
      int v;
      w = 6 + 2 * r;
      v = int'(smp) >> (12 - w);
      exp_word = right ? 16'(v) : 16'(v << (16 - w));
   endfunction : exp_word
   task automatic wait_done(input logic [3:0] sel, input bit ext,
         input bit diff);
      while (n < LIM && done !== 1'b1) begin
         @(posedge i_clk);
         #1;
         n++;
         if (mux.sample === 1'b1)
            chk(mux.pos_input === (sel[3] ? 3'h4 : {1'b0, sel[1:0]}) &&
               mux.use_ext_ref === (ext & ~sel[3]) &&
               mux.neg_is_input0 === diff, "mux steering");
      end
      if (n >= LIM) begin
         fails++;
         finish_test();
      end
   endtask : wait_done
   task automatic run_check(input int r, input logic [3:0] sel);
      n = 0;
      wait_done(sel, c.reference_select, c.differential);
      chk(n >= (r + 6) * DIV && n <= (r + 7) * DIV + 3, "latency");
      chk(result === exp_word(r, c.result_alignment) && flag === ovf,
         "result");
      @(posedge i_clk);
      #1;
      chk(done === 1'b0, "done width");
   endtask : run_check
   task automatic quiet(input int cyc);
      n = 0;
      repeat (cyc) begin
         @(posedge i_clk);
         #1;
         if (done === 1'b1)
            n++;
      end
   endtask : quiet
   task automatic new_sample();
      @(posedge i_clk);
      smp <= 12'($urandom);
      ovf <= 1'($urandom);
   endtask : new_sample
   initial begin
      void'($urandom(26));
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      c = 12'hc20;
      foreach (sels[k]) begin
         new_sample();
         c.result_alignment = 1'($urandom);
         c.reference_select = 1'($urandom);
         adccc_mcu_model_i.write_cfg(c);
         adccc_mcu_model_i.send_cmd(sels[k]);
         run_check(2, sels[k]);
      end
      for (int r = 0; r < 4; r++) begin
         for (int a = 0; a < 2; a++) begin
            new_sample();
            c.resolution_select = 2'(r);
            c.result_alignment = 1'(a);
            c.input_select = 4'(r);
            c.differential = (r != 0);
            c.start_trigger_n = 1'b0;
            adccc_mcu_model_i.write_cfg(c);
            c.start_trigger_n = 1'b1;
            adccc_mcu_model_i.write_cfg(c);
            run_check(r, 4'(r));
         end
      end
      c.continuous_run = 1'b1;
      c.start_trigger_n = 1'b0;
      adccc_mcu_model_i.write_cfg(c);
      c.start_trigger_n = 1'b1;
      adccc_mcu_model_i.write_cfg(c);
      run_check(3, 4'h3);
      n = 1;
      wait_done(4'h3, c.reference_select, c.differential);
      chk(n === 7 * DIV, "continuous interval");
      c.start_trigger_n = 1'b0;
      adccc_mcu_model_i.write_cfg(c);
      quiet(30 * DIV);
      chk(n === 0, "abort by start low");
      c.continuous_run = 1'b0;
      c.start_trigger_n = 1'b1;
      adccc_mcu_model_i.write_cfg(c);
      adccc_mcu_model_i.send_cmd(4'h1);
      repeat (3) @(posedge i_clk);
      adccc_mcu_model_i.send_cmd(4'h2);
      quiet(30 * DIV);
      chk(n === 1, "abort by new command");
      c.power_on = 1'b0;
      adccc_mcu_model_i.write_cfg(c);
      adccc_mcu_model_i.send_cmd(4'h1);
      quiet(30 * DIV);
      chk(n === 0 && mux.enable === 1'b0, "powered down");
      finish_test();
   end
endmodule : adc_conversion_control_bench
`default_nettype wire
